// ===== design/fault_flags_pkg.sv
// Purpose: shared constants for the charger fault and event flag bank
// Assumes: 8-bit registers on the serial management bus register space
// Notes:   bit positions, offsets, valid masks and source vector layout
package fault_flags_pkg;

  localparam int REG_W = 8;
  localparam int SRC_W = 16;
  localparam int RD_LATENCY = 1;

  // register offsets and reset value
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h24;
  localparam logic [7:0] ADDR_FLAGS_FIRST  = 8'h25;
  localparam logic [7:0] ADDR_FLAGS_SECOND = 8'h26;
  localparam logic [7:0] RESET_VALUE       = 8'h00;

  // implemented bits, reserved positions are zero
  localparam logic [7:0] FAULT_VALID  = 8'hFE;
  localparam logic [7:0] FIRST_VALID  = 8'hE9;
  localparam logic [7:0] SECOND_VALID = 8'hFA;

  // fault status bit positions
  localparam int FS_UV = 7, FS_OV = 6, FS_OC = 5, FS_BOV = 4;
  localparam int FS_TSHUT = 3, FS_TMR = 2, FS_GATE = 1;

  // first flag register bit positions
  localparam int F1_ADC = 7, F1_IAC = 6, F1_VAC = 5, F1_WD = 3, F1_CHG = 0;

  // second flag register bit positions
  localparam int F2_PG = 7, F2_INPUT_SWITCH_DRIVER = 6, F2_BATTERY_SWITCH_DRIVER = 5, F2_TS = 4;
  localparam int F2_REV = 3, F2_SYNC = 1;

  // source vector layout fed to the change detector
  localparam int S_ADC = 0, S_IAC = 1, S_VAC = 2, S_WD = 3, S_CHG = 4;
  localparam int S_PG = 7, S_INPUT_SWITCH_DRIVER = 8, S_BATTERY_SWITCH_DRIVER = 9, S_TS = 10;
  localparam int S_REV = 13, S_SYNC = 14;
  localparam logic [15:0] SRC_RISE = 16'h000F;

endpackage

// ===== design/flag_bus_if.sv
// Purpose: carries set, clear and state of one clear-on-read flag register
// Assumes: single clock domain
// Notes:   owner side holds the sticky bits
`timescale 1ns/1ns
interface flag_bus_if;
  logic [fault_flags_pkg::REG_W-1:0] set_pulse;
  logic                              read_clear;
  logic [fault_flags_pkg::REG_W-1:0] flags;
  modport owner (input set_pulse, input read_clear, output flags);
  modport user  (output set_pulse, output read_clear, input flags);
endinterface

// ===== design/event_edge_detect.sv
// Purpose: per-bit change detector for internal status sources
// Assumes: sources synchronous to i_clk
// Notes:   first cycle after reset only primes the history, no events
`timescale 1ns/1ns
module event_edge_detect #(
  parameter int               W    = fault_flags_pkg::SRC_W,
  parameter logic [W-1:0]     RISE = fault_flags_pkg::SRC_RISE
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_src,
  output logic      [W-1:0] o_change
);
  import fault_flags_pkg::*;

  logic [W-1:0] prev_reg;
  logic         primed_reg;

  // history of every source bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg   <= '0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg   <= i_src;
      primed_reg <= 1'b1;
    end
  end

  // rising-only bits need the new level high, others flag any toggle
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign o_change[b] = primed_reg & (i_src[b] ^ prev_reg[b]) & (~RISE[b] | i_src[b]);
  end
endmodule

// ===== design/flag_latch_reg.sv
// Purpose: sticky clear-on-read flag register
// Assumes: read_clear pulses in the cycle the register is read
// Notes:   a set arriving with the clear survives for the next read
`timescale 1ns/1ns
module flag_latch_reg #(
  parameter logic [7:0] VALID = 8'hFF
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  flag_bus_if.owner bus
);
  import fault_flags_pkg::*;

  logic [REG_W-1:0] flags_reg;
  logic [REG_W-1:0] flags_next;

  // set wins over clear, reserved bits never set
  assign flags_next = ((bus.read_clear ? RESET_VALUE : flags_reg) | bus.set_pulse) & VALID;
  assign bus.flags  = flags_reg;

  // sticky storage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= RESET_VALUE;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule

// ===== design/charger_fault_event_flags.sv
// Purpose: live fault status and clear-on-read event flag registers
// Assumes: serial bus engine gives one-cycle read and write strobes
// Notes:   read data appear one cycle after the strobe and hold
// Operation
// - fault bit 7 shows input undervoltage, bit 6 input overvoltage
// - fault bit 5 shows battery overcurrent, bit 4 battery overvoltage
// - fault bit 3 shows thermal shutdown, bit 2 safety timer expired
// - fault bit 1 shows gate driver supply out of valid range
// - battery only with converter measurement off forces fault bit 1 high
// - fault status and both flag registers reset to zero
// - first flag bit 7 latches conversion done only in one-shot mode
// - first flag bits 6 and 5 latch entry into input current/voltage limiting
// - first flag bit 3 latches watchdog expiry rising edge
// - first flag bit 0 latches any change of charge cycle state
// - second flag bit 7 latches any toggle of input power good
// - second flag bits 6 and 5 latch input and battery switch toggles
// - second flag bit 4 latches any change of thermistor state
// - second flag bit 3 latches reverse mode on or off
// - second flag bit 1 latches any change of sync input status
// - each latched event pulses the interrupt unless its mask bit is set
`timescale 1ns/1ns
module charger_fault_event_flags (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  input  wire logic                              i_rd_en,
  input  wire logic [7:0]                        i_rd_addr,
  input  wire logic                              i_wr_en,
  input  wire logic [7:0]                        i_wr_addr,
  output logic      [fault_flags_pkg::REG_W-1:0] o_rd_data,
  output logic                                   o_rd_valid,
  output logic                                   o_wr_refused,
  input  wire logic                              i_input_undervoltage_live,
  input  wire logic                              i_input_overvoltage_live,
  input  wire logic                              i_battery_overcurrent_live,
  input  wire logic                              i_battery_overvoltage_live,
  input  wire logic                              i_thermal_shutdown_live,
  input  wire logic                              i_safety_timer_expired_live,
  input  wire logic                              i_gate_supply_fault_live,
  input  wire logic                              i_battery_only_mode,
  input  wire logic                              i_adc_enabled,
  input  wire logic                              i_adc_oneshot_mode,
  input  wire logic                              i_adc_conversion_done,
  input  wire logic                              i_input_current_regulating,
  input  wire logic                              i_input_voltage_regulating,
  input  wire logic                              i_watchdog_expiry_status,
  input  wire logic [2:0]                        i_charge_cycle_state,
  input  wire logic                              i_input_power_good,
  input  wire logic                              i_input_switch_driver,
  input  wire logic                              i_battery_switch_driver,
  input  wire logic [2:0]                        i_thermistor_state,
  input  wire logic                              i_reverse_mode_on,
  input  wire logic [1:0]                        i_frequency_sync_input,
  input  wire logic [fault_flags_pkg::REG_W-1:0] i_mask_first,
  input  wire logic [fault_flags_pkg::REG_W-1:0] i_mask_second,
  output logic                                   o_int_pulse
);
  import fault_flags_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [REG_W-1:0] fault_status_reg;
  logic [REG_W-1:0] fault_status_next;
  logic [REG_W-1:0] rd_data_reg;
  logic [REG_W-1:0] rd_mux;
  logic             rd_valid_reg, wr_refused_reg, int_pulse_reg;
  logic             gate_supply_bit;
  logic             hit_fault, hit_first, hit_second, wr_hit;
  logic [SRC_W-1:0] src_vec;
  logic [SRC_W-1:0] change;
  logic [REG_W-1:0] first_set, second_set, first_view;
  logic             int_cause;

  flag_bus_if first_bus ();
  flag_bus_if second_bus ();

  // ------------------------------------------------------------
  // live fault status
  // ------------------------------------------------------------

  // gate supply bit is forced high when its monitor is not running
  assign gate_supply_bit = i_gate_supply_fault_live
                         | (i_battery_only_mode & ~i_adc_enabled);

  // fault snapshot, bit 0 reserved
  assign fault_status_next = {
    i_input_undervoltage_live, i_input_overvoltage_live,
    i_battery_overcurrent_live, i_battery_overvoltage_live,
    i_thermal_shutdown_live, i_safety_timer_expired_live,
    gate_supply_bit, 1'b0
  };

  // fault status follows the protection states each cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_status_reg <= RESET_VALUE;
    end else begin
      fault_status_reg <= fault_status_next & FAULT_VALID;
    end
  end

  // ------------------------------------------------------------
  // event sources and change detection
  // ------------------------------------------------------------

  // source vector, low four bits detect rising edges only
  assign src_vec = {i_frequency_sync_input, i_reverse_mode_on, i_thermistor_state,
                    i_battery_switch_driver, i_input_switch_driver, i_input_power_good,
                    i_charge_cycle_state, i_watchdog_expiry_status, i_input_voltage_regulating,
                    i_input_current_regulating, i_adc_conversion_done};

  event_edge_detect #(.W (SRC_W), .RISE (SRC_RISE)) u_detect (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_src    (src_vec),
    .o_change (change)
  );

  // first flag register set pulses, bits 7 down to 0
  assign first_set = {
    change[S_ADC] & i_adc_oneshot_mode,
    change[S_IAC],
    change[S_VAC],
    1'b0,
    change[S_WD],
    2'b00,
    |change[S_CHG +: 3]
  };

  // second flag register set pulses, bits 7 down to 0
  assign second_set = {
    change[S_PG],
    change[S_INPUT_SWITCH_DRIVER],
    change[S_BATTERY_SWITCH_DRIVER],
    |change[S_TS +: 3],
    change[S_REV],
    1'b0,
    |change[S_SYNC +: 2],
    1'b0
  };

  // ------------------------------------------------------------
  // sticky flag registers
  // ------------------------------------------------------------

  // clear on read, a simultaneous set survives
  assign first_bus.set_pulse   = first_set;
  assign first_bus.read_clear  = i_rd_en & hit_first;
  assign second_bus.set_pulse  = second_set;
  assign second_bus.read_clear = i_rd_en & hit_second;

  flag_latch_reg #(
    .VALID (FIRST_VALID)
  ) u_first (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (first_bus)
  );

  flag_latch_reg #(
    .VALID (SECOND_VALID)
  ) u_second (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (second_bus)
  );

  // ------------------------------------------------------------
  // register read and write decode
  // ------------------------------------------------------------

  // address decode
  assign hit_fault  = (i_rd_addr == ADDR_FAULT_STATUS);
  assign hit_first  = (i_rd_addr == ADDR_FLAGS_FIRST);
  assign hit_second = (i_rd_addr == ADDR_FLAGS_SECOND);
  assign wr_hit     = (i_wr_addr == ADDR_FAULT_STATUS)
                    | (i_wr_addr == ADDR_FLAGS_FIRST)
                    | (i_wr_addr == ADDR_FLAGS_SECOND);

  // conversion flag reads zero outside one-shot mode
  assign first_view = first_bus.flags & {i_adc_oneshot_mode, 7'h7F};

  // read selection, other offsets answer zero
  assign rd_mux = hit_fault  ? fault_status_reg :
                  hit_first  ? first_view :
                  hit_second ? second_bus.flags : RESET_VALUE;

  // read data hold until the next read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_reg  <= RESET_VALUE;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= i_rd_en ? rd_mux : rd_data_reg;
      rd_valid_reg <= i_rd_en;
    end
  end

  // writes to this bank change nothing and are reported
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_refused_reg <= 1'b0;
    end else begin
      wr_refused_reg <= i_wr_en & wr_hit;
    end
  end

  // ------------------------------------------------------------
  // interrupt pulse
  // ------------------------------------------------------------

  // one pulse per cycle with any unmasked latched event
  assign int_cause = |(first_set & ~i_mask_first & FIRST_VALID)
                   | |(second_set & ~i_mask_second & SECOND_VALID);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_pulse_reg <= 1'b0;
    end else begin
      int_pulse_reg <= int_cause;
    end
  end

  assign o_rd_data    = rd_data_reg;
  assign o_rd_valid   = rd_valid_reg;
  assign o_wr_refused = wr_refused_reg;
  assign o_int_pulse  = int_pulse_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_rd_fault;
    i_rd_en && hit_fault;
  endsequence

  sequence s_rd_first;
    i_rd_en && hit_first;
  endsequence

  sequence s_rd_second;
    i_rd_en && hit_second;
  endsequence

  // settled source one edge ahead of the read
  property p_uv_ov;
    s_rd_fault and ($past(i_rst_n) && $stable(i_input_undervoltage_live))
    |=> o_rd_data[FS_UV] == $past(i_input_undervoltage_live)
        && o_rd_data[FS_OV] == $past(i_input_overvoltage_live, 2);
  endproperty
  a_uv_ov: assert property (p_uv_ov)
    else $error("fault bits 7/6 do not follow input voltage protection");

  property p_batt;
    s_rd_fault and $past(i_rst_n) |=> o_rd_data[FS_OC] == $past(i_battery_overcurrent_live, 2)
                   && o_rd_data[FS_BOV] == $past(i_battery_overvoltage_live, 2);
  endproperty
  a_batt: assert property (p_batt)
    else $error("fault bits 5/4 do not follow battery protection");

  property p_therm_tmr;
    s_rd_fault and $past(i_rst_n) |=> o_rd_data[FS_TSHUT] == $past(i_thermal_shutdown_live, 2)
                   && o_rd_data[FS_TMR] == $past(i_safety_timer_expired_live, 2);
  endproperty
  a_therm_tmr: assert property (p_therm_tmr)
    else $error("fault bits 3/2 do not follow shutdown or timer");

  property p_gate;
    s_rd_fault and $past(i_rst_n) && $past(i_adc_enabled || !i_battery_only_mode)
    |=> o_rd_data[FS_GATE] == $past(i_gate_supply_fault_live, 2);
  endproperty
  a_gate: assert property (p_gate)
    else $error("fault bit 1 does not follow gate supply");

  property p_gate_forced;
    s_rd_fault and $past(i_rst_n) && $past(i_battery_only_mode && !i_adc_enabled)
    |=> o_rd_data[FS_GATE];
  endproperty
  a_gate_forced: assert property (p_gate_forced)
    else $error("fault bit 1 not forced in battery only mode");

  property p_reset;
    @(posedge i_clk) disable iff (1'b0)
    !i_rst_n |-> o_rd_data == RESET_VALUE && first_bus.flags == RESET_VALUE
                 && second_bus.flags == RESET_VALUE && !o_int_pulse;
  endproperty
  a_reset: assert property (p_reset)
    else $error("registers not zero during reset");

  property p_adc_cont;
    s_rd_first and !i_adc_oneshot_mode |=> !o_rd_data[F1_ADC];
  endproperty
  a_adc_cont: assert property (p_adc_cont)
    else $error("conversion flag read as one in continuous mode");

  property p_iac_rise;
    $past(i_rst_n) && $rose(i_input_current_regulating) |=> first_bus.flags[F1_IAC];
  endproperty
  a_iac_rise: assert property (p_iac_rise)
    else $error("current limit entry not latched");

  property p_wd_fall;
    $fell(i_watchdog_expiry_status) && !first_bus.flags[F1_WD] && !first_bus.read_clear
    |=> !first_bus.flags[F1_WD];
  endproperty
  a_wd_fall: assert property (p_wd_fall)
    else $error("watchdog flag set on falling edge");

  property p_chg;
    $past(i_rst_n) && $changed(i_charge_cycle_state) |=> first_bus.flags[F1_CHG];
  endproperty
  a_chg: assert property (p_chg)
    else $error("charge state change not latched");

  property p_pg;
    $past(i_rst_n) && $changed(i_input_power_good) ##1 s_rd_second
    |=> o_rd_data[F2_PG];
  endproperty
  a_pg: assert property (p_pg)
    else $error("power good toggle not reported on read");

  property p_ts;
    $past(i_rst_n) && $changed(i_thermistor_state) |=> second_bus.flags[F2_TS];
  endproperty
  a_ts: assert property (p_ts)
    else $error("thermistor change not latched");

  property p_int;
    int_cause |=> o_int_pulse;
  endproperty
  a_int: assert property (p_int)
    else $error("unmasked event gave no interrupt pulse");

  property p_masked;
    (first_set & ~i_mask_first) == 8'h00 && (second_set & ~i_mask_second) == 8'h00
    |=> !o_int_pulse;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked event gave interrupt pulse");

  property p_hold;
    !first_bus.read_clear |=> (first_bus.flags & $past(first_bus.flags))
                              == $past(first_bus.flags);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without a read");

  property p_reserved;
    s_rd_fault or s_rd_first or s_rd_second |=> (o_rd_data & ~($past(hit_fault) ?
      FAULT_VALID : $past(hit_first) ? FIRST_VALID : SECOND_VALID)) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit read as one");

  property p_same_cycle;
    s_rd_second and (second_set != 8'h00) |=> second_bus.flags == $past(second_set);
  endproperty
  a_same_cycle: assert property (p_same_cycle)
    else $error("event lost during read of its register");

endmodule

// ===== bench/host_model.sv
// Purpose: host side of the register strobe bus, issues reads and writes
// Assumes: tasks are entered just after a rising edge of i_clk
// Notes:   address lines show the inverse once a request is no longer taken
`timescale 1ns/1ns
module host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_en,
  output logic [7:0]      o_rd_addr,
  output logic            o_wr_en,
  output logic [7:0]      o_wr_addr
);
  // idle bus at time zero
  initial begin
    o_rd_en   = 1'b0;
    o_rd_addr = 8'h00;
    o_wr_en   = 1'b0;
    o_wr_addr = 8'h00;
  end

  // one read: strobe taken at the next edge, data caught while valid is high
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    o_rd_en   <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_clk);
    o_rd_en   <= 1'b0;
    o_rd_addr <= ~a;
    @(negedge i_clk);
    while (i_rd_valid !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    d = (n < 8) ? i_rd_data : 8'hXX; // no answer gives unknown data
    @(posedge i_clk);
  endtask

  // one write strobe, the device is expected to refuse it
  task automatic wr(input logic [7:0] a);
    o_wr_en   <= 1'b1;
    o_wr_addr <= a;
    @(posedge i_clk);
    o_wr_en   <= 1'b0;
    o_wr_addr <= ~a;
    @(posedge i_clk);
  endtask
endmodule

// ===== bench/test_charger_fault_event_flags.sv
// Purpose: self-checking bench for the fault status and event flag bank
// Assumes: xorshift stimulus from seed 24792, inputs change on rising edges
// Notes:   expected values come from bench functions and tables only
`timescale 1ns/1ns
module test_charger_fault_event_flags;
  import fault_flags_pkg::*;
  logic i_clk, i_rst_n, rd_en, wr_en, rd_valid, wr_refused, int_pulse;
  logic [7:0] rd_addr, wr_addr, rd_data, m1, m2, d;
  logic [9:0] flt;
  logic       done, iac, vac, wd, pg, acf, bsw, rev, oneshot;
  logic [2:0] chg, ts;
  logic [1:0] sync;
  int errors, num_checks, int_cnt, ref_cnt, c;
  logic [31:0] seed = 32'd24792;
  int pos[11] = '{F1_ADC, F1_IAC, F1_VAC, F1_WD, F1_CHG, F2_PG, F2_INPUT_SWITCH_DRIVER,
                  F2_BATTERY_SWITCH_DRIVER, F2_TS, F2_REV, F2_SYNC};

  // ----------------------------------------
  // clock, connections and pulse counters
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  host_model host (.i_clk(i_clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_wr_en(wr_en), .o_wr_addr(wr_addr));
  charger_fault_event_flags DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_wr_refused(wr_refused),
    .i_input_undervoltage_live(flt[7]), .i_input_overvoltage_live(flt[6]),
    .i_battery_overcurrent_live(flt[5]), .i_battery_overvoltage_live(flt[4]),
    .i_thermal_shutdown_live(flt[3]), .i_safety_timer_expired_live(flt[2]),
    .i_gate_supply_fault_live(flt[1]), .i_battery_only_mode(flt[8]),
    .i_adc_enabled(flt[9]), .i_adc_oneshot_mode(oneshot),
    .i_adc_conversion_done(done), .i_input_current_regulating(iac),
    .i_input_voltage_regulating(vac), .i_watchdog_expiry_status(wd),
    .i_charge_cycle_state(chg), .i_input_power_good(pg),
    .i_input_switch_driver(acf), .i_battery_switch_driver(bsw),
    .i_thermistor_state(ts), .i_reverse_mode_on(rev),
    .i_frequency_sync_input(sync), .i_mask_first(m1), .i_mask_second(m2),
    .o_int_pulse(int_pulse));
  always @(posedge i_clk) begin
    if (int_pulse === 1'b1) int_cnt++;
    if (wr_refused === 1'b1) ref_cnt++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // fault status image, gate bit forced in battery-only with measurement off
  function automatic logic [7:0] fault_exp(input logic [9:0] r);
    return {r[7:2], r[1] | (r[8] & ~r[9]), 1'b0};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one change of event source i, rise-only sources alternate up and down
  task automatic ev(input int i);
    case (i)
      0: done <= ~done;
      1: iac <= ~iac;
      2: vac <= ~vac;
      3: wd <= ~wd;
      4: chg <= chg ^ 3'h5;
      5: pg <= ~pg;
      6: acf <= ~acf;
      7: bsw <= ~bsw;
      8: ts <= ts ^ 3'h3;
      9: rev <= ~rev;
      default: sync <= sync ^ 2'h2;
    endcase
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {flt, done, iac, vac, wd, pg, acf, bsw, rev, chg, ts, sync} = '0;
    {m1, m2} = '0;
    oneshot = 1'b1;
    i_rst_n = 1'b0;
    cyc(3);
    i_rst_n <= 1'b1;
    cyc(2);
    for (int a = 8'h24; a <= 8'h27; a++) begin
      host.rd(8'(a), d);
      chk(d, 8'h00);
    end
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      flt <= (k == 0) ? 10'h100 : seed[9:0];
      cyc(2);
      host.rd(ADDR_FAULT_STATUS, d);
      chk(d, fault_exp(flt));
    end
    $display("test fault status done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 11; i++) begin
        c = int_cnt;
        ev(i);
        cyc(3);
        chk(8'(int_cnt - c), (p == 0 || i > 3) ? 8'h01 : 8'h00);
        host.rd((i < 5) ? ADDR_FLAGS_FIRST : ADDR_FLAGS_SECOND, d);
        chk(d, (p == 0 || i > 3) ? 8'(1 << pos[i]) : 8'h00);
        host.rd((i < 5) ? ADDR_FLAGS_FIRST : ADDR_FLAGS_SECOND, d);
        chk(d, 8'h00);
      end
    end
    $display("test event flags done");
    oneshot <= 1'b0;
    ev(0);
    cyc(3);
    host.rd(ADDR_FLAGS_FIRST, d);
    chk(d, 8'h00);
    ev(1);
    cyc(2);
    ev(1);
    cyc(3);
    host.rd(ADDR_FLAGS_FIRST, d);
    chk(d, 8'h40);
    ev(5);
    host.rd(ADDR_FLAGS_SECOND, d);
    chk(d, 8'h00);
    host.rd(ADDR_FLAGS_SECOND, d);
    chk(d, 8'h80);
    ev(5);
    cyc(1);
    host.rd(ADDR_FLAGS_SECOND, d);
    chk(d, 8'h80);
    $display("test hold and same-cycle event done");
    ev(6);
    cyc(3);
    c = ref_cnt;
    host.wr(ADDR_FLAGS_SECOND);
    cyc(1);
    chk(8'(ref_cnt - c), 8'h01);
    host.rd(ADDR_FLAGS_SECOND, d);
    chk(d, 8'h40);
    m1 <= 8'hFF;
    m2 <= 8'hFF;
    cyc(1);
    c = int_cnt;
    ev(7);
    cyc(3);
    chk(8'(int_cnt - c), 8'h00);
    host.rd(ADDR_FLAGS_SECOND, d);
    chk(d, 8'h20);
    $display("test write and mask done");
    wrap_up();
  end

  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule
